/* File: rtl/lcd_seg_pkg.sv */
// constants, register map and types for the segment display driver
package lcd_seg_pkg;

    // ==========================================================
    // register offsets (byte addresses on the plain register port)
    localparam logic [7:0] OFF_DISPLAY_CONTROL = 8'h00;
    localparam logic [7:0] OFF_PHASE_PRESCALE  = 8'h01;
    localparam logic [7:0] OFF_SEG_ENABLE_LOW  = 8'h02;
    localparam logic [7:0] OFF_SEG_ENABLE_MID  = 8'h03;
    localparam logic [7:0] OFF_SEG_ENABLE_HIGH = 8'h04;
    localparam logic [7:0] OFF_PIXEL_BASE      = 8'h05;
    localparam logic [7:0] PIXEL_REG_COUNT     = 8'h0C;

    // ==========================================================
    // display_control fields
    localparam int CTRL_DRIVER_ON       = 7;
    localparam int CTRL_SLEEP_DRIVE_OFF = 6;
    localparam int CTRL_SRC_HI          = 3;
    localparam int CTRL_SRC_LO          = 2;
    localparam int CTRL_MUX_HI          = 1;
    localparam int CTRL_MUX_LO          = 0;
    localparam logic [7:0] CTRL_RESET     = 8'h13;
    localparam logic [7:0] CTRL_WR_MASK   = 8'hDF;

    // phase_prescale_config fields
    localparam int PHASE_TYPE_B    = 7;
    localparam int PHASE_BIAS_HALF = 6;
    localparam int PHASE_ACTIVE    = 5;
    localparam int PHASE_PS_HI     = 3;
    localparam logic [7:0] PHASE_RESET   = 8'h00;
    localparam logic [7:0] PHASE_WR_MASK = 8'hCF;
    localparam logic [7:0] SEG_EN_RESET  = 8'h00;
    localparam logic [7:0] PIXEL_RESET   = 8'h00;

    // ==========================================================
    // geometry and timing
    localparam int NUM_COMMONS  = 4;
    localparam int NUM_SEGMENTS = 24;
    localparam int SMALL_SEGS   = 16;
    localparam int INT_DIV_DEFAULT = 32;

    // ==========================================================
    // drive level codes, V0 lowest to V3 highest
    localparam logic [1:0] LVL_V0 = 2'h0;
    localparam logic [1:0] LVL_V1 = 2'h1;
    localparam logic [1:0] LVL_V2 = 2'h2;
    localparam logic [1:0] LVL_V3 = 2'h3;

    typedef enum logic {ST_OFF, ST_RUN} drive_state_type;

endpackage : lcd_seg_pkg

/* File: rtl/lcd_segment_driver_ctrl.sv */
// segment display driver: registers, frame timing and common/segment levels
`timescale 1ns/1ps
module lcd_segment_driver_ctrl
    import lcd_seg_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int INT_DIV       = INT_DIV_DEFAULT
)(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // alternate frame clock sources, one-cycle ticks
    input  wire logic                  ext_tick_a,
    input  wire logic                  ext_tick_b,
    // device power state
    input  wire logic                  sleep_mode,
    // panel side
    output logic [NUM_COMMONS-1:0][1:0]  com_level,
    output logic [NUM_SEGMENTS-1:0][1:0] seg_level,
    output logic [NUM_SEGMENTS-1:0]      segment_pin_select,
    output logic                         drive_active,
    output logic                         frame_start
);

    // ==========================================================
    // register storage
    logic [7:0]            ctrl_q;
    logic [7:0]            phase_q;
    logic [7:0]            seg_en_q [0:2];
    logic [7:0]            pix_q    [0:11];
    logic [7:0]            rdata_q;
    logic [7:0]            rdata_d;

    wire        sel_ctrl  = (reg_addr == OFF_DISPLAY_CONTROL);
    wire        sel_phase = (reg_addr == OFF_PHASE_PRESCALE);
    wire        sel_se0   = (reg_addr == OFF_SEG_ENABLE_LOW);
    wire        sel_se1   = (reg_addr == OFF_SEG_ENABLE_MID);
    // third segment-enable register absent on the small variant
    wire        sel_se2   = (reg_addr == OFF_SEG_ENABLE_HIGH) && LARGE_VARIANT;
    wire [7:0]  pix_off   = reg_addr - OFF_PIXEL_BASE;
    wire        sel_pix   = (reg_addr >= OFF_PIXEL_BASE) && (pix_off < PIXEL_REG_COUNT);
    wire [3:0]  pix_idx   = pix_off[3:0];

    wire        driver_on  = ctrl_q[CTRL_DRIVER_ON];
    wire        sleep_off  = ctrl_q[CTRL_SLEEP_DRIVE_OFF];
    wire [1:0]  src_sel    = ctrl_q[CTRL_SRC_HI:CTRL_SRC_LO];
    wire [1:0]  mux_sel    = ctrl_q[CTRL_MUX_HI:CTRL_MUX_LO];
    wire        type_b     = phase_q[PHASE_TYPE_B];
    wire        bias_half  = phase_q[PHASE_BIAS_HALF];
    wire [3:0]  prescale   = phase_q[PHASE_PS_HI:0];

    drive_state_type state_q;
    drive_state_type state_d;

    // ==========================================================
    // register writes
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctrl_q  <= CTRL_RESET;
            phase_q <= PHASE_RESET;
            for (int i = 0; i < 3; i++)
                seg_en_q[i] <= SEG_EN_RESET;
            for (int i = 0; i < 12; i++)
                pix_q[i] <= PIXEL_RESET;
        end
        else if (reg_wr)
        begin
            if (sel_ctrl)
                ctrl_q <= reg_wdata & CTRL_WR_MASK;
            else if (sel_phase)
                phase_q <= reg_wdata & PHASE_WR_MASK;
            else if (sel_se0)
                seg_en_q[0] <= reg_wdata;
            else if (sel_se1)
                seg_en_q[1] <= reg_wdata;
            else if (sel_se2)
                seg_en_q[2] <= reg_wdata;
            else if (sel_pix)
                pix_q[pix_idx] <= reg_wdata;
        end
    end

    // ==========================================================
    // register reads, data in the cycle after the strobe only
    always_comb
    begin
        rdata_d = 8'h00;
        if (sel_ctrl)
            rdata_d = ctrl_q;
        else if (sel_phase)
            rdata_d = phase_q | {2'h0, (state_q == ST_RUN), 5'h00};
        else if (sel_se0)
            rdata_d = seg_en_q[0];
        else if (sel_se1)
            rdata_d = seg_en_q[1];
        else if (sel_se2)
            rdata_d = seg_en_q[2];
        else if (sel_pix)
            rdata_d = pix_q[pix_idx];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            rdata_q <= 8'h00;
        else
            rdata_q <= reg_rd ? rdata_d : 8'h00;
    end

    assign reg_rdata = rdata_q;

    // ==========================================================
    // run control
    // sleep only stops the panel when software asked for it
    wire run_req = driver_on && !(sleep_mode && sleep_off);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_OFF:
                if (run_req)
                    state_d = ST_RUN;
            ST_RUN:
                if (!run_req)
                    state_d = ST_OFF;
            default:
                state_d = ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state_q <= ST_OFF;
        else
            state_q <= state_d;
    end

    wire running = (state_q == ST_RUN);

    // ==========================================================
    // frame clock source and prescaler
    logic [7:0] int_cnt_q;
    logic [3:0] ps_cnt_q;

    wire int_tick = (int_cnt_q == 8'(INT_DIV - 1));
    wire src_tick = (src_sel == 2'h0) ? int_tick :
                    (src_sel == 2'h1) ? ext_tick_a : ext_tick_b;
    wire phase_tick = running && src_tick && (ps_cnt_q == prescale);

    always_ff @(posedge ref_clk)
    begin
        if (rst || int_tick)
            int_cnt_q <= 8'h00;
        else
            int_cnt_q <= int_cnt_q + 8'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || !running || phase_tick)
            ps_cnt_q <= 4'h0;
        else if (src_tick)
            ps_cnt_q <= ps_cnt_q + 4'h1;
    end

    // ==========================================================
    // common and polarity sequencer
    logic [1:0] com_idx_q;
    logic       pol_q;

    wire last_com   = (com_idx_q == mux_sel);
    // type A flips polarity inside each common slot, type B once a frame
    wire frame_wrap = phase_tick && last_com && (type_b || pol_q);

    always_ff @(posedge ref_clk)
    begin
        if (rst || !running)
        begin
            com_idx_q <= 2'h0;
            pol_q     <= 1'b0;
        end
        else if (phase_tick)
        begin
            if (type_b)
            begin
                com_idx_q <= last_com ? 2'h0 : com_idx_q + 2'h1;
                pol_q     <= last_com ? !pol_q : pol_q;
            end
            else if (!pol_q)
                pol_q <= 1'b1;
            else
            begin
                pol_q     <= 1'b0;
                com_idx_q <= last_com ? 2'h0 : com_idx_q + 2'h1;
            end
        end
    end

    // ==========================================================
    // pixel shadow, refreshed at frame boundaries while running and every cycle while stopped
    // avoids half-updated digits tearing inside a frame
    logic [NUM_SEGMENTS-1:0] shadow_q [0:NUM_COMMONS-1];

    genvar c;
    generate
        for (c = 0; c < NUM_COMMONS; c++)
        begin : g_shadow
            // third pixel register per common drives nothing when small
            wire [7:0] high_bits = LARGE_VARIANT ? pix_q[3*c+2] : 8'h00;
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                    shadow_q[c] <= '0;
                else if (!running || frame_wrap)
                    shadow_q[c] <= {high_bits, pix_q[3*c+1], pix_q[3*c]};
            end
        end
    endgenerate

    // ==========================================================
    // level generation
    wire bias_static = (mux_sel == 2'h0);
    wire [NUM_SEGMENTS-1:0] seg_mask = LARGE_VARIANT ? {NUM_SEGMENTS{1'b1}} :
                                       {{(NUM_SEGMENTS-SMALL_SEGS){1'b0}},
                                        {SMALL_SEGS{1'b1}}};
    wire [NUM_SEGMENTS-1:0] seg_en_all = {seg_en_q[2], seg_en_q[1], seg_en_q[0]} & seg_mask;
    wire [NUM_SEGMENTS-1:0] cur_pix    = shadow_q[com_idx_q];

    logic [NUM_COMMONS-1:0][1:0]  com_level_d;
    logic [NUM_SEGMENTS-1:0][1:0] seg_level_d;

    generate
        for (c = 0; c < NUM_COMMONS; c++)
        begin : g_com
            wire used = (2'(c) <= mux_sel);
            wire sel  = (2'(c) == com_idx_q);
            assign com_level_d[c] = !running || !used ? LVL_V0 :
                                    sel ? (pol_q ? LVL_V0 : LVL_V3) :
                                    bias_half ? LVL_V1 :
                                    (pol_q ? LVL_V2 : LVL_V1);
        end
    endgenerate

    genvar s;
    generate
        for (s = 0; s < NUM_SEGMENTS; s++)
        begin : g_seg
            wire [1:0] clear_lvl = (bias_static || bias_half) ?
                                   (pol_q ? LVL_V0 : LVL_V3) :
                                   (pol_q ? LVL_V1 : LVL_V2);
            wire [1:0] dark_lvl  = pol_q ? LVL_V3 : LVL_V0;
            assign seg_level_d[s] = !running || !seg_en_all[s] ? LVL_V0 :
                                    cur_pix[s] ? dark_lvl : clear_lvl;
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            com_level          <= '0;
            seg_level          <= '0;
            segment_pin_select <= '0;
            drive_active       <= 1'b0;
            frame_start        <= 1'b0;
        end
        else
        begin
            com_level          <= com_level_d;
            seg_level          <= seg_level_d;
            segment_pin_select <= seg_en_all;
            drive_active       <= running;
            frame_start        <= frame_wrap;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_enable_start: assert property (
        (state_q == ST_OFF) && driver_on && !(sleep_mode && sleep_off)
        |=> running ##1 drive_active)
        else $error("driver did not start after enable");

    a_sleep_stop: assert property (
        running && sleep_mode && sleep_off |=> !running ##1 !drive_active)
        else $error("driver kept running in sleep with drive off set");

    a_sleep_keep: assert property (
        running && driver_on && !sleep_off |=> running)
        else $error("driver stopped although sleep drive was kept");

    a_off_quiet: assert property (
        !drive_active |-> (com_level == '0) && (seg_level == '0))
        else $error("panel driven while driver inactive");

    a_small_high: assert property (
        !LARGE_VARIANT |-> (segment_pin_select[NUM_SEGMENTS-1:SMALL_SEGS] == '0))
        else $error("upper segments selected on small variant");

    a_seg_disabled: assert property (
        !seg_en_all[0] |=> (seg_level[0] == LVL_V0))
        else $error("disabled segment pin driven");

    a_shadow_hold: assert property (
        running && !frame_wrap |=> $stable(shadow_q[0]) && $stable(shadow_q[3]))
        else $error("pixel shadow changed inside a frame");

    // two internal ticks per step, so seven quiet cycles once INT_DIV >= 4
    a_prescale_gap: assert property (
        phase_tick && (prescale == 4'h1) && (src_sel == 2'h0) && running
        && (INT_DIV >= 4) && $stable(phase_q) |=> !phase_tick [*7])
        else $error("phase tick came too soon after prescaler reload");

    a_com_range: assert property (
        running |-> (com_idx_q <= mux_sel) || $changed(mux_sel))
        else $error("common index beyond selected multiplex");

    a_static_dark: assert property (
        running && bias_static && cur_pix[0] && seg_en_all[0]
        |=> drive_active && (seg_level[0] != com_level[0]))
        else $error("dark pixel not driven opposite to common");

    a_read_idle: assert property (
        !reg_rd |=> (reg_rdata == 8'h00))
        else $error("read data present without a read strobe");

    a_unused_com: assert property (
        running && (mux_sel != 2'h3) |=> (com_level[3] == LVL_V0))
        else $error("unused common driven");

    a_half_unsel: assert property (
        running && bias_half && (mux_sel != 2'h0) && (com_idx_q != 2'h1)
        |=> (com_level[1] == LVL_V1))
        else $error("unselected common not at half bias level");

    a_com_select: assert property (
        running && (com_idx_q == 2'h0) && !pol_q |=> (com_level[0] == LVL_V3))
        else $error("selected common not at top level");

    a_small_pixels: assert property (
        !LARGE_VARIANT |-> (seg_level[NUM_SEGMENTS-1:SMALL_SEGS] == '0))
        else $error("upper segments driven on small variant");

endmodule : lcd_segment_driver_ctrl

/* File: sim/lcd_panel_model.sv */
// passive multiplexed panel that recovers which pixels are driven dark
`timescale 1ns/1ps
module lcd_panel_model
    import lcd_seg_pkg::*;
(
    // clock and reset
    input  wire logic                                 ref_clk,
    input  wire logic                                 rst,
    // drive from the driver
    input  wire logic [NUM_COMMONS-1:0][1:0]          com_level,
    input  wire logic [NUM_SEGMENTS-1:0][1:0]         seg_level,
    input  wire logic [NUM_SEGMENTS-1:0]              segment_pin_select,
    input  wire logic                                 frame_start,
    // highest common wired to the glass
    input  wire logic [1:0]                           last_common,
    // picture seen over the last whole frame
    output logic [NUM_COMMONS-1:0][NUM_SEGMENTS-1:0]  panel_image
);
    // ==========================================================
    // full-swing detection
    logic [NUM_COMMONS-1:0][NUM_SEGMENTS-1:0] seen_q;
    logic [NUM_COMMONS-1:0][NUM_SEGMENTS-1:0] now_dark;

    // only a full V0/V3 swing turns a cell; port pins are not glass
    always_comb
    begin
        for (int c = 0; c < NUM_COMMONS; c++)
            for (int s = 0; s < NUM_SEGMENTS; s++)
                now_dark[c][s] = (c <= last_common) && segment_pin_select[s] && (
                    (com_level[c] == LVL_V3 && seg_level[s] == LVL_V0) ||
                    (com_level[c] == LVL_V0 && seg_level[s] == LVL_V3));
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            seen_q      <= '0;
            panel_image <= '0;
        end
        else if (frame_start)
        begin
            panel_image <= seen_q;
            seen_q      <= now_dark;
        end
        else
            seen_q <= seen_q | now_dark;
    end
endmodule : lcd_panel_model

/* File: sim/lcd_segment_driver_ctrl_tb.sv */
// self-checking bench for the segment display driver
`timescale 1ns/1ps
module lcd_segment_driver_ctrl_tb;
    import lcd_seg_pkg::*;
    // ==========================================================
    // signals and bench model
    logic                              ref_clk;
    logic                              rst;
    logic [7:0]                        reg_addr;
    logic [7:0]                        reg_wdata;
    logic                              reg_wr;
    logic                              reg_rd;
    logic [7:0]                        reg_rdata;
    logic                              ext_tick_a = 1'b0;
    logic                              ext_tick_b = 1'b0;
    logic [1:0]                        panel_last_com;
    logic                              sleep_mode;
    logic [NUM_COMMONS-1:0][1:0]       com_level;
    logic [NUM_SEGMENTS-1:0][1:0]      seg_level;
    logic [NUM_SEGMENTS-1:0]           segment_pin_select;
    logic                              drive_active;
    logic                              frame_start;
    logic [NUM_COMMONS-1:0][23:0]      panel_image;
    logic [7:0]                        exp_reg [0:16];
    logic [31:0]                       lfsr = 32'hD7C5;
    logic [3:0]                        tick_cnt = 4'h0;
    logic [7:0]                        cfg_ctrl [3] = '{8'h83, 8'h85, 8'h88};
    logic [7:0]                        cfg_phase [3] = '{8'h01, 8'h40, 8'h80};
    int                                n_errors = 0;
    int                                n_tests = 0;

    lcd_segment_driver_ctrl #(.LARGE_VARIANT(1'b1), .INT_DIV(4)) u_lcd_segment_driver_ctrl (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_tick_a(ext_tick_a),
        .ext_tick_b(ext_tick_b), .sleep_mode(sleep_mode), .com_level(com_level),
        .seg_level(seg_level), .segment_pin_select(segment_pin_select),
        .drive_active(drive_active), .frame_start(frame_start));

    lcd_panel_model u_lcd_panel_model (
        .ref_clk(ref_clk), .rst(rst), .com_level(com_level), .seg_level(seg_level),
        .segment_pin_select(segment_pin_select), .frame_start(frame_start),
        .last_common(panel_last_com), .panel_image(panel_image));

    // ==========================================================
    // clock and slow external ticks
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        tick_cnt   <= tick_cnt + 4'h1;
        ext_tick_a <= (tick_cnt == 4'h2);
        ext_tick_b <= (tick_cnt == 4'h9);
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        lfsr_next = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr_next

    // status bit follows the model's idea of running
    function automatic logic [7:0] exp_read(input int a);
        logic run;
        run = exp_reg[0][7] && !(sleep_mode && exp_reg[0][6]);
        if (a > 16)
            return 8'h00;
        return (a == 1) ? (exp_reg[1] | (run ? 8'h20 : 8'h00)) : exp_reg[a];
    endfunction : exp_read

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] want);
        n_tests++;
        if (got !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: read %h want %h", $time, got, want);
        end
    endtask : cmp_reg

    task automatic cmp_vec(input logic [23:0] got, input logic [23:0] want);
        n_tests++;
        if (got !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: vector %h want %h", $time, got, want);
        end
    endtask : cmp_vec

    task automatic cmp_flag(input logic got, input logic want);
        n_tests++;
        if (got !== want)
        begin
            n_errors++;
            $display("unexpected at %0t: flag %b want %b", $time, got, want);
        end
    endtask : cmp_flag

    task automatic wr_reg(input int a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a[7:0];
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        if (a == 0)
            exp_reg[0] = (d & CTRL_WR_MASK) | (CTRL_RESET & ~CTRL_WR_MASK);
        else if (a == 1)
            exp_reg[1] = d & PHASE_WR_MASK;
        else if (a <= 16)
            exp_reg[a] = d;
    endtask : wr_reg

    task automatic rd_chk(input int a);
        @(posedge ref_clk);
        reg_addr <= a[7:0];
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        cmp_reg(reg_rdata, exp_read(a));
    endtask : rd_chk

    // bounded wait; a missing frame counts as a mismatch
    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 5000)
        begin
            @(posedge ref_clk);
            #1;
            k++;
            if (frame_start === 1'b1)
                n--;
        end
        cmp_flag(n == 0, 1'b1);
    endtask : wait_frames

    // unused commons carry no picture
    task automatic chk_image(input int mux);
        logic [23:0] want;
        // the panel latches its picture one edge after the frame pulse
        @(posedge ref_clk);
        #1;
        for (int c = 0; c < NUM_COMMONS; c++)
        begin
            want = {exp_reg[7+3*c], exp_reg[6+3*c], exp_reg[5+3*c]}
                 & {exp_reg[4], exp_reg[3], exp_reg[2]};
            cmp_vec(panel_image[c], (c > mux) ? 24'h0 : want);
        end
    endtask : chk_image

    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    // ==========================================================
    // watchdog
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        n_errors++;
        $display("unexpected at %0t: run took too long", $time);
        results();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sleep_mode = 1'b0;
        panel_last_com = 2'h0;
        for (int i = 0; i < 17; i++)
            exp_reg[i] = (i == 0) ? CTRL_RESET : 8'h00;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 18; a++)
            rd_chk(a);
        $display("test reset values done");
        for (int a = 0; a < 18; a++)
        begin
            lfsr = lfsr_next(lfsr);
            wr_reg(a, (a == 0) ? (lfsr[7:0] & 8'h7C) : lfsr[7:0]);
        end
        for (int a = 0; a < 18; a++)
            rd_chk(a);
        cmp_vec(segment_pin_select, {exp_reg[4], exp_reg[3], exp_reg[2]});
        $display("test register map done");
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(0, 8'h00);
            panel_last_com = cfg_ctrl[k][1:0];
            wr_reg(1, cfg_phase[k]);
            for (int a = 5; a < 17; a++)
            begin
                lfsr = lfsr_next(lfsr);
                wr_reg(a, lfsr[7:0]);
            end
            wr_reg(0, cfg_ctrl[k]);
            wait_frames(3);
            cmp_flag(drive_active, 1'b1);
            rd_chk(1);
            chk_image(cfg_ctrl[k][1:0]);
            lfsr = lfsr_next(lfsr);
            wr_reg(5, exp_reg[5] | lfsr[7:0]);
            wait_frames(2);
            chk_image(cfg_ctrl[k][1:0]);
            $display("test display config %0d done", k);
        end
        sleep_mode <= 1'b1;
        wait_frames(2);
        cmp_flag(drive_active, 1'b1);
        wr_reg(0, cfg_ctrl[2] | 8'h40);
        repeat (8) @(posedge ref_clk);
        #1;
        cmp_flag(drive_active, 1'b0);
        cmp_vec({16'h0, com_level}, 24'h0);
        sleep_mode <= 1'b0;
        wr_reg(0, 8'h08);
        repeat (8) @(posedge ref_clk);
        #1;
        cmp_flag(drive_active, 1'b0);
        $display("test sleep and disable done");
        results();
    end
endmodule : lcd_segment_driver_ctrl_tb
